// ==== common/audio_regs_consts.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the host register bank.
// Assumes: Byte addresses inside a 64-byte I/O window.
// Notes: Included by its bare name.
`ifndef AUDIO_REGS_CONSTS_SVH
`define AUDIO_REGS_CONSTS_SVH

// Register word offsets
`define OFF_UART_WORD 6'h08
`define OFF_PAGE 6'h0C
`define OFF_RATE_CONV 6'h10
`define OFF_MAILBOX 6'h14
`define OFF_LEGACY 6'h18
`define OFF_WIN_LO 6'h30
`define OFF_WIN_HI 6'h3F

// UART test bit sits in byte lane 2 of the word at 08H
`define UART_TEST_BIT 16

// Rate converter port fields
`define RC_LOC_HI 31
`define RC_LOC_LO 25
`define RC_WE_BIT 24
`define RC_PEND_BIT 23
`define RC_OFF_BIT 22
`define RC_P1_BIT 21
`define RC_P2_BIT 20
`define RC_REC_BIT 19

// Mailbox fields
`define MB_READY_BIT 31
`define MB_PEND_BIT 30
`define MB_RD_BIT 23
`define MB_IDX_HI 22
`define MB_IDX_LO 16

// Legacy control fields
`define LG_JFAST_BIT 31
`define LG_HIB_BIT 30
`define LG_SB_BIT 29
`define LG_BASE_HI 28
`define LG_BASE_LO 27
`define LG_CDC_HI 26
`define LG_CDC_LO 25

// Reset values
`define RST_WORD 32'h0000_0000
`define RST_PAGE 4'h0

// Decode range bases
`define SB_BASE_LO 16'h0220
`define SB_BASE_HI 16'h0240
`define BASE_RANGE_0 16'h0320
`define BASE_RANGE_STEP 16'h0010
`define CDC_RANGE_0 16'h0530
`define CDC_RANGE_2 16'h0E80
`define CDC_RANGE_3 16'h0F40

// Pending flag must rise within this many clocks of the access
`define RC_PEND_MAX_NS 12
`define CLK_PERIOD_NS 4
`define RC_PEND_MAX_CYC (`RC_PEND_MAX_NS / `CLK_PERIOD_NS)

`endif

// ==== common/audio_regs_pkg.sv ====
// Purpose: Types shared by the host register bank and its bench.
// Assumes: Constants come from audio_regs_consts.svh.
// Notes: None.
package audio_regs_pkg;

  // One outstanding operation on a back end
  typedef enum logic [0:0] {
    OP_IDLE = 1'b0,
    OP_BUSY = 1'b1
  } op_state_t;

  typedef logic [5:0] reg_addr_t;
  typedef logic [31:0] reg_word_t;

endpackage

// ==== design/audio_host_indirect_access_regs.sv ====
// Purpose: Host-visible page, rate converter, codec mailbox, legacy and UART test registers.
// Assumes: One 250 MHz clock; host strobes are single-cycle and synchronous.
// Notes: Every read answers two clocks after its strobe.
`include "audio_regs_consts.svh"
`timescale 1ns/1ns
`default_nettype none

// How it works
// - UART test bit set switches the UART clock to the bus clock; clear after reset.
// - Four-bit page field in bits 3:0 picks one of sixteen pages.
// - Offsets 30H-3FH reach sixteen bytes of the selected page.
// - Page register bits 31:4 are not kept; they read as zero.
// - Converter port holds location 31:25, write select 24, value 15:0.
// - Converter pending flag bit 23 rises within three clocks of an access.
// - Converter pending flag clears once the RAM operation finishes.
// - Bit 22 set turns the rate converter off.
// - Bits 21, 20, 19 hold playback one, playback two, record accumulator updates.
// - Every longword mailbox write starts one codec register read or write.
// - Mailbox write: read flag 23, register index 22:16, value 15:0.
// - Mailbox read: bit 31 valid read data, bit 30 access in progress.
// - Mailbox read: zeros 29:24, read flag 23, index 22:16, data 15:0.
// - Legacy upper half is control, lower half status; bit 0 both.
// - Legacy bit 31 picks fast joystick timing, else ISA timing.
// - Legacy bit 30 enables interrupt blocking, effective only with DMA config set.
// - Legacy bit 29 picks game-audio range 220xH or 240xH.
// - Legacy bits 28:27 pick base range 320xH to 350xH.
// - Legacy bits 26:25 pick codec range 530xH, E80xH, F40xH; 01 undefined.
// - Game-audio capture decodes the range chosen by legacy bit 29.
module audio_host_indirect_access_regs (
  input wire logic i_clk,
  input wire logic i_srst,
  // Host register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire audio_regs_pkg::reg_addr_t i_reg_addr,
  input wire logic [3:0] i_reg_be,
  input wire audio_regs_pkg::reg_word_t i_reg_wdata,
  output audio_regs_pkg::reg_word_t o_reg_rdata,
  output logic o_reg_rvalid,
  // Paged memory window
  output logic [3:0] o_mem_page,
  output logic o_page_wr,
  output logic o_page_rd,
  output logic [7:0] o_page_addr,
  output logic [3:0] o_page_be,
  output logic [31:0] o_page_wdata,
  input wire logic [31:0] i_page_rdata,
  // Rate converter RAM
  output logic o_rc_req,
  output logic o_rc_we,
  output logic [6:0] o_rc_loc,
  output logic [15:0] o_rc_wdata,
  input wire logic i_rc_done,
  input wire logic [15:0] i_rc_rdata,
  output logic o_rate_conv_off,
  output logic o_play_one_accum_hold,
  output logic o_play_two_accum_hold,
  output logic o_record_accum_hold,
  // Codec register link
  output logic o_codec_req,
  output logic o_codec_rd,
  output logic [6:0] o_codec_idx,
  output logic [15:0] o_codec_wdata,
  input wire logic i_codec_done,
  input wire logic [15:0] i_codec_rdata,
  // Legacy side
  input wire logic i_dma_cfg,
  input wire logic [15:0] i_legacy_status,
  output logic o_legacy_flag_clear,
  output logic o_joy_fast,
  output logic o_host_int_block,
  output logic [15:0] o_sb_range_base,
  output logic [15:0] o_base_range_base,
  output logic [15:0] o_cdc_range_base,
  output logic o_cdc_range_valid,
  // UART
  output logic o_uart_test_clk_sel
);
  import audio_regs_pkg::*;
  logic [3:0] page_q;
  logic uart_test_q;
  logic [15:0] rc_value_q;
  op_state_t rc_state_q;
  logic [23:16] mb_req_q;
  logic [15:0] mb_res_q;
  logic mb_ready_q;
  op_state_t mb_state_q;
  logic [6:0] lg_ctl_q;
  logic rd_stage_q;
  logic rd_win_q;
  reg_addr_t rd_addr_q;
  reg_word_t rd_word;
  // Address decode, word registers compare bits 5:2
  wire logic hit_uart = (i_reg_addr[5:2] == 4'(`OFF_UART_WORD >> 2));
  wire logic hit_page = (i_reg_addr[5:2] == 4'(`OFF_PAGE >> 2));
  wire logic hit_rc = (i_reg_addr[5:2] == 4'(`OFF_RATE_CONV >> 2));
  wire logic hit_mb = (i_reg_addr[5:2] == 4'(`OFF_MAILBOX >> 2));
  wire logic hit_lg = (i_reg_addr[5:2] == 4'(`OFF_LEGACY >> 2));
  wire logic hit_win = (i_reg_addr >= `OFF_WIN_LO) && (i_reg_addr <= `OFF_WIN_HI);
  wire logic full_word = (i_reg_be == 4'hF);
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      uart_test_q <= 1'b0;
    end else if (i_reg_wr && hit_uart && i_reg_be[2]) begin
      uart_test_q <= i_reg_wdata[`UART_TEST_BIT];
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      page_q <= `RST_PAGE;
    end else if (i_reg_wr && hit_page && i_reg_be[0]) begin
      page_q <= i_reg_wdata[3:0];
    end
  end
  // Forward window accesses with the page number on top
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_page_wr <= 1'b0;
      o_page_rd <= 1'b0;
      o_page_addr <= 8'h00;
      o_page_be <= 4'h0;
      o_page_wdata <= `RST_WORD;
    end else begin
      o_page_wr <= i_reg_wr && hit_win;
      o_page_rd <= i_reg_rd && hit_win;
      if ((i_reg_wr || i_reg_rd) && hit_win) begin
        o_page_addr <= {page_q, i_reg_addr[3:0]};
        o_page_be <= i_reg_be;
        o_page_wdata <= i_reg_wdata;
      end
    end
  end
  // Converter value: host write data, or RAM read result
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rc_value_q <= 16'h0000;
    end else if (rc_state_q == OP_BUSY && i_rc_done && !o_rc_we) begin
      rc_value_q <= i_rc_rdata;
    end else if (i_reg_wr && hit_rc && full_word && rc_state_q == OP_IDLE) begin
      rc_value_q <= i_reg_wdata[15:0];
    end
  end
  // Pending rises one clock after the write
  // and drops on the completion strobe
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rc_state_q <= OP_IDLE;
      o_rc_req <= 1'b0;
    end else begin
      o_rc_req <= 1'b0;
      unique case (rc_state_q)
        OP_IDLE: begin
          if (i_reg_wr && hit_rc && full_word) begin
            rc_state_q <= OP_BUSY;
            o_rc_req <= 1'b1;
          end
        end
        OP_BUSY: begin
          if (i_rc_done) begin
            rc_state_q <= OP_IDLE;
          end
        end
      endcase
    end
  end
  // Converter fields, longword writes only; read back from here too
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rc_we <= 1'b0;
      o_rc_loc <= 7'h00;
      o_rc_wdata <= 16'h0000;
      o_rate_conv_off <= 1'b0;
      o_play_one_accum_hold <= 1'b0;
      o_play_two_accum_hold <= 1'b0;
      o_record_accum_hold <= 1'b0;
    end else begin
      if (i_reg_wr && hit_rc && full_word && rc_state_q == OP_IDLE) begin
        o_rc_we <= i_reg_wdata[`RC_WE_BIT];
        o_rc_loc <= i_reg_wdata[`RC_LOC_HI:`RC_LOC_LO];
        o_rc_wdata <= i_reg_wdata[15:0];
      end
      if (i_reg_wr && hit_rc && full_word) begin
        o_rate_conv_off <= i_reg_wdata[`RC_OFF_BIT];
        o_play_one_accum_hold <= i_reg_wdata[`RC_P1_BIT];
        o_play_two_accum_hold <= i_reg_wdata[`RC_P2_BIT];
        o_record_accum_hold <= i_reg_wdata[`RC_REC_BIT];
      end
    end
  end
  // Every longword mailbox write launches one codec access
  // Request fields taken from the write
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mb_req_q <= 8'h00;
      mb_state_q <= OP_IDLE;
      o_codec_req <= 1'b0;
      o_codec_rd <= 1'b0;
      o_codec_idx <= 7'h00;
      o_codec_wdata <= 16'h0000;
    end else begin
      o_codec_req <= 1'b0;
      if (i_reg_wr && hit_mb && full_word) begin
        mb_req_q <= i_reg_wdata[`MB_RD_BIT:`MB_IDX_LO];
        mb_state_q <= OP_BUSY;
        o_codec_req <= 1'b1;
        o_codec_rd <= i_reg_wdata[`MB_RD_BIT];
        o_codec_idx <= i_reg_wdata[`MB_IDX_HI:`MB_IDX_LO];
        o_codec_wdata <= i_reg_wdata[15:0];
      end else if (mb_state_q == OP_BUSY && i_codec_done) begin
        mb_state_q <= OP_IDLE;
      end
    end
  end
  // Valid read data flag; a new request clears it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mb_ready_q <= 1'b0;
      mb_res_q <= 16'h0000;
    end else if (i_reg_wr && hit_mb && full_word) begin
      mb_ready_q <= 1'b0;
    end else if (mb_state_q == OP_BUSY && i_codec_done) begin
      mb_ready_q <= mb_req_q[`MB_RD_BIT];
      if (mb_req_q[`MB_RD_BIT]) begin
        mb_res_q <= i_codec_rdata;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lg_ctl_q <= 7'h00;
    end else if (i_reg_wr && hit_lg && i_reg_be[3]) begin
      lg_ctl_q <= i_reg_wdata[31:25];
    end
  end
  // Any write to bit 0 clears the legacy flag
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_legacy_flag_clear <= 1'b0;
    end else begin
      o_legacy_flag_clear <= i_reg_wr && hit_lg && i_reg_be[0];
    end
  end
  // Legacy control outputs
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_joy_fast <= 1'b0;
      o_host_int_block <= 1'b0;
      o_sb_range_base <= `SB_BASE_LO;
      o_base_range_base <= `BASE_RANGE_0;
      o_cdc_range_base <= `CDC_RANGE_0;
      o_cdc_range_valid <= 1'b1;
    end else begin
      o_joy_fast <= lg_ctl_q[`LG_JFAST_BIT - 25];
      o_host_int_block <= lg_ctl_q[`LG_HIB_BIT - 25] && i_dma_cfg;
      // Game-audio range, used by its capture
      o_sb_range_base <= lg_ctl_q[`LG_SB_BIT - 25] ? `SB_BASE_HI : `SB_BASE_LO;
      o_base_range_base <= `BASE_RANGE_0 +
        16'(lg_ctl_q[`LG_BASE_HI - 25:`LG_BASE_LO - 25]) * `BASE_RANGE_STEP;
      // Codec range; code 01 has no range and is flagged invalid
      o_cdc_range_valid <= (lg_ctl_q[`LG_CDC_HI - 25:`LG_CDC_LO - 25] != 2'b01);
      unique case (lg_ctl_q[`LG_CDC_HI - 25:`LG_CDC_LO - 25])
        2'b00: o_cdc_range_base <= `CDC_RANGE_0;
        2'b01: o_cdc_range_base <= `CDC_RANGE_0;
        2'b10: o_cdc_range_base <= `CDC_RANGE_2;
        2'b11: o_cdc_range_base <= `CDC_RANGE_3;
      endcase
    end
  end
  // Register mirrors to top-level outputs
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_mem_page <= `RST_PAGE;
      o_uart_test_clk_sel <= 1'b0;
    end else begin
      o_mem_page <= page_q;
      // Clock select follows the test bit
      o_uart_test_clk_sel <= uart_test_q;
    end
  end
  // Read pipeline stage one: remember what was asked
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rd_stage_q <= 1'b0;
      rd_win_q <= 1'b0;
      rd_addr_q <= 6'h00;
    end else begin
      rd_stage_q <= i_reg_rd;
      rd_win_q <= i_reg_rd && hit_win;
      if (i_reg_rd) begin
        rd_addr_q <= i_reg_addr;
      end
    end
  end
  // Read mux over the current register state
  always_comb begin
    rd_word = `RST_WORD;
    if (rd_win_q) begin
      rd_word = i_page_rdata;
    end else begin
      unique case (rd_addr_q[5:2])
        4'(`OFF_UART_WORD >> 2): rd_word[`UART_TEST_BIT] = uart_test_q;
        4'(`OFF_PAGE >> 2): rd_word[3:0] = page_q;
        4'(`OFF_RATE_CONV >> 2): begin
          rd_word[`RC_LOC_HI:`RC_LOC_LO] = o_rc_loc;
          rd_word[`RC_WE_BIT] = o_rc_we;
          rd_word[`RC_PEND_BIT] = (rc_state_q == OP_BUSY);
          rd_word[`RC_OFF_BIT] = o_rate_conv_off;
          rd_word[`RC_P1_BIT] = o_play_one_accum_hold;
          rd_word[`RC_P2_BIT] = o_play_two_accum_hold;
          rd_word[`RC_REC_BIT] = o_record_accum_hold;
          rd_word[15:0] = rc_value_q;
        end
        4'(`OFF_MAILBOX >> 2): begin
          rd_word[`MB_READY_BIT] = mb_ready_q;
          rd_word[`MB_PEND_BIT] = (mb_state_q == OP_BUSY);
          rd_word[`MB_RD_BIT:`MB_IDX_LO] = mb_req_q[`MB_RD_BIT:`MB_IDX_LO];
          rd_word[15:0] = mb_res_q;
        end
        4'(`OFF_LEGACY >> 2): begin
          rd_word[31:25] = lg_ctl_q;
          rd_word[15:0] = i_legacy_status;
        end
        default: rd_word = `RST_WORD;
      endcase
    end
  end
  // Read pipeline stage two: answer
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_reg_rvalid <= 1'b0;
      o_reg_rdata <= `RST_WORD;
    end else begin
      o_reg_rvalid <= rd_stage_q;
      if (rd_stage_q) begin
        o_reg_rdata <= rd_word;
      end
    end
  end
endmodule

`default_nettype wire

// ==== bench/audio_regs_properties.sv ====
// Purpose: Port-level checks of the host register bank.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the bank from the bench top.
`timescale 1ns/1ns
`default_nettype none
`include "audio_regs_consts.svh"
module audio_regs_checker (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr,
  input wire audio_regs_pkg::reg_addr_t i_reg_addr,
  input wire logic [3:0] i_reg_be,
  input wire audio_regs_pkg::reg_word_t i_reg_wdata,
  input wire logic o_rc_req,
  input wire logic o_rc_we,
  input wire logic [6:0] o_rc_loc,
  input wire logic i_rc_done,
  input wire logic o_rate_conv_off,
  input wire logic o_play_one_accum_hold,
  input wire logic o_play_two_accum_hold,
  input wire logic o_record_accum_hold,
  input wire logic o_codec_req,
  input wire logic o_codec_rd,
  input wire logic [6:0] o_codec_idx,
  input wire logic i_dma_cfg,
  input wire logic o_legacy_flag_clear,
  input wire logic o_host_int_block,
  input wire logic [15:0] o_sb_range_base,
  input wire logic [15:0] o_base_range_base,
  input wire logic o_uart_test_clk_sel
);
  import audio_regs_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  logic rc_busy_q;
  // Decoded host writes
  wire logic [5:0] wa = {i_reg_addr[5:2], 2'b00};
  wire logic rc_wr = i_reg_wr && wa == `OFF_RATE_CONV && i_reg_be == 4'hF;
  wire logic mb_wr = i_reg_wr && wa == `OFF_MAILBOX;
  wire logic lg_wr = i_reg_wr && wa == `OFF_LEGACY;
  wire logic rc_busy = rc_busy_q || o_rc_req;
  // One converter RAM operation in flight, start pulse to done
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rc_busy_q <= 1'b0;
    end else if (o_rc_req) begin
      rc_busy_q <= 1'b1;
    end else if (i_rc_done) begin
      rc_busy_q <= 1'b0;
    end
  end
  a_rc_start: assert property (
    rc_wr && !rc_busy |=> o_rc_req && {o_rc_loc, o_rc_we} == $past(i_reg_wdata[31:24]))
    else $error("converter op did not start");
  a_rc_refuse: assert property (
    rc_wr && rc_busy |=> !o_rc_req)
    else $error("converter op started while busy");
  a_rc_holds: assert property (
    rc_wr |=> {o_rate_conv_off, o_play_one_accum_hold, o_play_two_accum_hold, o_record_accum_hold}
      == $past(i_reg_wdata[22:19]))
    else $error("converter control bits wrong");
  a_mb_start: assert property (
    mb_wr && i_reg_be == 4'hF |=> o_codec_req && {o_codec_rd, o_codec_idx} == $past(i_reg_wdata[23:16]))
    else $error("codec access did not start");
  a_mb_partial: assert property (
    mb_wr && i_reg_be != 4'hF |=> !o_codec_req)
    else $error("partial mailbox write started access");
  a_range_sel: assert property (
    lg_wr && i_reg_be[3] |-> ##3 o_sb_range_base == ($past(i_reg_wdata[29], 3) ? `SB_BASE_HI : `SB_BASE_LO)
      && o_base_range_base == `BASE_RANGE_0 + {10'h000, $past(i_reg_wdata[28:27], 3), 4'h0})
    else $error("capture range base wrong");
  a_flag_clear: assert property (
    lg_wr && i_reg_be[0] |=> o_legacy_flag_clear)
    else $error("legacy flag clear missing");
  a_hib_gate: assert property (
    !i_dma_cfg && !$past(i_dma_cfg) |-> !o_host_int_block)
    else $error("interrupt blocking without dma config");
  a_uart_sel: assert property (
    i_reg_wr && wa == `OFF_UART_WORD && i_reg_be[2] |=> ##1
      o_uart_test_clk_sel == $past(i_reg_wdata[`UART_TEST_BIT], 2))
    else $error("uart clock select wrong");
endmodule
`default_nettype wire

// ==== bench/codec_partner_model.sv ====
// Purpose: Codec register file and converter RAM behind the bank.
// Assumes: One request at a time per side.
// Notes: Answers after 1 or 20 clocks; data lines toggle when idle.
`timescale 1ns/1ns
`default_nettype none
module codec_partner_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_slow,
  input wire logic i_codec_req,
  input wire logic i_codec_rd,
  input wire logic [6:0] i_codec_idx,
  input wire logic [15:0] i_codec_wdata,
  output logic o_codec_done,
  output logic [15:0] o_codec_rdata,
  input wire logic i_rc_req,
  input wire logic i_rc_we,
  input wire logic [6:0] i_rc_loc,
  input wire logic [15:0] i_rc_wdata,
  output logic o_rc_done,
  output logic [15:0] o_rc_rdata
);
  logic [15:0] creg [128];
  logic [15:0] ram [128];
  logic [4:0] cw_q, rw_q;
  logic [6:0] cidx_q, rloc_q;
  // Codec side, idle data inverts every clock
  // read flag, index and value taken as one request
  always_ff @(posedge i_clk) begin
    o_codec_done <= 1'b0;
    o_codec_rdata <= ~o_codec_rdata;
    if (i_srst) begin
      cw_q <= 5'h0;
      o_codec_rdata <= 16'hC3A5;
    end else if (i_codec_req) begin
      cw_q <= i_slow ? 5'h14 : 5'h1;
      cidx_q <= i_codec_idx;
      if (!i_codec_rd) begin
        creg[i_codec_idx] <= i_codec_wdata;
      end
    end else if (cw_q != 5'h0) begin
      cw_q <= cw_q - 5'h1;
      o_codec_done <= cw_q == 5'h1;
      o_codec_rdata <= creg[cidx_q];
    end
  end
  // Converter RAM side
  // done marks the finished RAM operation
  always_ff @(posedge i_clk) begin
    o_rc_done <= 1'b0;
    o_rc_rdata <= ~o_rc_rdata;
    if (i_srst) begin
      rw_q <= 5'h0;
      o_rc_rdata <= 16'h5A3C;
    end else if (i_rc_req) begin
      rw_q <= i_slow ? 5'h14 : 5'h1;
      rloc_q <= i_rc_loc;
      if (i_rc_we) begin
        ram[i_rc_loc] <= i_rc_wdata;
      end
    end else if (rw_q != 5'h0) begin
      rw_q <= rw_q - 5'h1;
      o_rc_done <= rw_q == 5'h1;
      o_rc_rdata <= ram[rloc_q];
    end
  end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench of the host register bank.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Checker bound at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import audio_regs_pkg::*;
  logic i_clk, i_srst, i_reg_wr, i_reg_rd, i_dma_cfg, slow, o_reg_rvalid, o_page_wr, o_page_rd;
  logic o_rc_req, o_rc_we, i_rc_done, o_codec_req, o_codec_rd, i_codec_done, o_legacy_flag_clear;
  logic o_rate_conv_off, o_play_one_accum_hold, o_play_two_accum_hold, o_record_accum_hold;
  logic o_joy_fast, o_host_int_block, o_cdc_range_valid, o_uart_test_clk_sel;
  reg_addr_t i_reg_addr;
  reg_word_t i_reg_wdata, o_reg_rdata, rd;
  logic [3:0] i_reg_be, o_mem_page, o_page_be;
  logic [31:0] o_page_wdata, i_page_rdata;
  logic [7:0] o_page_addr;
  logic [6:0] o_rc_loc, o_codec_idx;
  logic [15:0] o_rc_wdata, i_rc_rdata, o_codec_wdata, i_codec_rdata, i_legacy_status;
  logic [15:0] o_sb_range_base, o_base_range_base, o_cdc_range_base;
  logic [16:0] cdc [4] = '{17'h1_0530, 17'h0_0530, 17'h1_0E80, 17'h1_0F40};
  int err_total, check_count;

  audio_host_indirect_access_regs u_audio_host_indirect_access_regs (.*);
  codec_partner_model u_codec_partner_model (
    .i_clk(i_clk), .i_srst(i_srst), .i_slow(slow), .i_codec_req(o_codec_req), .i_codec_rd(o_codec_rd),
    .i_codec_idx(o_codec_idx), .i_codec_wdata(o_codec_wdata), .o_codec_done(i_codec_done),
    .o_codec_rdata(i_codec_rdata), .i_rc_req(o_rc_req), .i_rc_we(o_rc_we), .i_rc_loc(o_rc_loc),
    .i_rc_wdata(o_rc_wdata), .o_rc_done(i_rc_done), .o_rc_rdata(i_rc_rdata)
  );

  // Clock, 4 ns period
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe; returns in the cycle after it is taken
  task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge i_clk) #1;
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_be = be;
    i_reg_wdata = d;
    @(posedge i_clk) #1;
    i_reg_wr = 1'b0;
  endtask

  // Read answer lands two clocks after the strobe edge
  task automatic rdw(input logic [5:0] a);
    @(posedge i_clk) #1;
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(posedge i_clk) #1;
    i_reg_rd = 1'b0;
    chk("page rd", o_page_rd, a >= 6'h30);
    @(posedge i_clk) #1;
    chk("rvalid", o_reg_rvalid, 1'b1);
    rd = o_reg_rdata;
  endtask

  // Bounded wait for a busy bit to drop
  task automatic poll(input logic [5:0] a, input int b);
    int n;
    n = 0;
    do begin
      rdw(a);
      n++;
    end while (rd[b] !== 1'b0 && n < 40);
    chk("busy drops", rd[b], 1'b0);
  endtask

  task automatic t_reset_uart();
    chk("ranges", {o_sb_range_base, o_base_range_base}, 32'h0220_0320);
    chk("cdc range", {o_cdc_range_valid, o_cdc_range_base}, 17'h1_0530);
    chk("uart idle", o_uart_test_clk_sel, 1'b0);
    rdw(6'h14);
    chk("mailbox idle", rd, 32'h0000_0000);
    wr(6'h08, 4'b0100, 32'h0001_0000);
    @(posedge i_clk) #1;
    chk("uart on", o_uart_test_clk_sel, 1'b1);
    rdw(6'h08);
    chk("uart read", rd, 32'h0001_0000);
    wr(6'h08, 4'b0100, 32'h0000_0000);
    @(posedge i_clk) #1;
    chk("uart off", o_uart_test_clk_sel, 1'b0);
  endtask

  task automatic t_page();
    for (int p = 0; p < 2; p++) begin
      wr(6'h0C, 4'b0001, p ? 32'h0000_0000 : 32'hFFFF_FFFF);
      rdw(6'h0C);
      chk("page", {o_mem_page, rd[3:0]}, p ? 8'h00 : 8'hFF);
      wr(p ? 6'h30 : 6'h3F, 4'hF, 32'h1357_9BDF);
      chk("window", {o_page_wr, o_page_addr}, p ? 9'h100 : 9'h1FF);
      chk("window data", o_page_wdata, 32'h1357_9BDF);
      chk("window be", o_page_be, 4'hF);
    end
    rdw(6'h34);
    chk("window addr", o_page_addr, 8'h04);
    chk("window read", rd, i_page_rdata);
    rdw(6'h2C);
    chk("below window", rd, 32'h0000_0000);
  endtask

  task automatic t_rate_conv();
    slow = 1'b0;
    wr(6'h10, 4'hF, 32'hAB00_BEEF);
    chk("ram start", {o_rc_req, o_rc_we, o_rc_loc}, 9'h1D5);
    chk("ram wdata", o_rc_wdata, 16'hBEEF);
    poll(6'h10, 23);
    slow = 1'b1;
    wr(6'h10, 4'hF, 32'hAA50_0000);
    rdw(6'h10);
    chk("ram busy", rd[23], 1'b1);
    wr(6'h10, 4'hF, 32'h0228_1111);
    chk("holds", {o_rate_conv_off, o_play_one_accum_hold, o_play_two_accum_hold, o_record_accum_hold}, 4'h5);
    poll(6'h10, 23);
    chk("ram read", rd, 32'hAA28_BEEF);
  endtask

  task automatic t_mailbox();
    slow = 1'b0;
    wr(6'h14, 4'hF, 32'h002A_1234);
    chk("codec start", {o_codec_req, o_codec_rd, o_codec_idx}, 9'h12A);
    chk("codec wdata", o_codec_wdata, 16'h1234);
    poll(6'h14, 30);
    chk("write result", rd[31:16], 16'h002A);
    slow = 1'b1;
    wr(6'h14, 4'hF, 32'h00AA_0000);
    rdw(6'h14);
    chk("in progress", rd[31:30], 2'b01);
    poll(6'h14, 30);
    chk("read result", rd, 32'h80AA_1234);
    wr(6'h14, 4'h3, 32'h0000_0000);
    rdw(6'h14);
    chk("partial ignored", rd, 32'h80AA_1234);
  endtask

  task automatic t_legacy();
    for (int c = 0; c < 4; c++) begin
      i_dma_cfg = c[0];
      wr(6'h18, 4'b1001, {c[0], 1'b1, c[0], c[1:0], c[1:0], 25'h000_0000});
      chk("flag clear", o_legacy_flag_clear, 1'b1);
      repeat (3) @(posedge i_clk) #1;
      chk("joy fast", o_joy_fast, c[0]);
      chk("int block", o_host_int_block, c[0]);
      chk("sb range", o_sb_range_base, c[0] ? 16'h0240 : 16'h0220);
      chk("base range", o_base_range_base, 16'h0320 + 16'(c * 16));
      chk("cdc range", {o_cdc_range_valid, o_cdc_range_base}, cdc[c]);
      rdw(6'h18);
      chk("legacy read", rd, {c[0], 1'b1, c[0], c[1:0], c[1:0], 9'h000, i_legacy_status});
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    err_total = 0;
    check_count = 0;
    i_srst = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 6'h00;
    i_reg_be = 4'h0;
    i_reg_wdata = 32'h0000_0000;
    i_dma_cfg = 1'b0;
    slow = 1'b0;
    i_page_rdata = 32'hA5C3_0F96;
    i_legacy_status = 16'h5A3C;
    repeat (5) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    t_reset_uart();
    t_page();
    t_rate_conv();
    t_mailbox();
    t_legacy();
    report_and_stop();
  end

  // Watchdog, about seventy times the expected run
  initial begin
    #40000;
    err_total++;
    report_and_stop();
  end
endmodule

bind audio_host_indirect_access_regs audio_regs_checker u_audio_regs_checker (.*);
`default_nettype wire
